/* File: inc/eep_pkg.sv */
package eep_pkg;

  localparam int ADDR_W_DEF      = 14;
  localparam int PAGE_W_DEF      = 6;
  localparam int FIFO_DEPTH_DEF  = 16;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WRITE_CYCLE_TIME_NS = 5000;
  localparam int WR_CYCLES_DEF   = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int BYTE_W          = 8;
  localparam int ADDR_HI_W       = 16 - BYTE_W;
  localparam int WORD_BYTES      = 4;
  localparam int WORD_SEL_W      = 2;
  localparam int WORD_W          = 32;
  localparam int CHK_W           = 6;
  localparam int HAM_POS         = WORD_W + CHK_W;
  localparam int PIN_W           = 6;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  localparam int SEL_TYPE_MSB    = 7;
  localparam int SEL_TYPE_LSB    = 4;
  localparam int SEL_CS_MSB      = 3;
  localparam int SEL_CS_LSB      = 1;
  localparam int SEL_RW_BIT      = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_BUSY
  } eep_state_t;

  // Hamming code over 38 positions; check bits sit at the power-of-two positions
  function automatic logic [CHK_W-1:0] ecc_gen(input logic [WORD_W-1:0] d);
    logic [CHK_W-1:0] c;
    int               k;
    c = '0;
    k = 0;
    for (int p = 1; p <= HAM_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < CHK_W; j++) begin
          if (p[j]) c[j] = c[j] ^ d[k];
        end
        k++;
      end
    end
    return c;
  endfunction : ecc_gen

  function automatic logic [WORD_W-1:0] ecc_fix(input logic [WORD_W-1:0] d,
                                                input logic [CHK_W-1:0]  chk);
    logic [CHK_W-1:0]  s;
    logic [WORD_W-1:0] o;
    int                k;
    s = ecc_gen(d) ^ chk;
    o = d;
    k = 0;
    for (int p = 1; p <= HAM_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p == int'(s)) o[k] = ~o[k];
        k++;
      end
    end
    return o;
  endfunction : ecc_fix

endpackage : eep_pkg

/* File: inc/eep_fifo_if.sv */
`timescale 1ns/1ps
interface eep_fifo_if #(parameter int W = 14) ();
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface : eep_fifo_if

/* File: rtl/eep_sync.sv */
`timescale 1ns/1ps
module eep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic [2:0] s_r;
      logic       q_r;
      // A change is taken only once the second and third stages agree
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          s_r <= 3'h0;
          q_r <= 1'b0;
        end else begin
          s_r <= {s_r[1:0], d_i[g]};
          if (s_r[1] == s_r[2]) q_r <= s_r[2];
        end
      end
      assign q_o[g] = q_r;
    end
  endgenerate
endmodule : eep_sync

/* File: rtl/eep_fifo.sv */
`timescale 1ns/1ps
module eep_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = eep_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  eep_fifo_if.fifo  f
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("eep_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         full;
  logic         empty;

  assign full         = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  assign empty        = (wp_r == rp_r);
  assign f.push_ready = !full;
  assign f.pop_valid  = !empty;
  assign f.pop_data   = mem_r[rp_r[PW-1:0]];

  always_ff @(posedge clk_i) begin
    if (f.push_valid && !full) mem_r[wp_r[PW-1:0]] <= f.push_data;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= '0;
    end else if (f.push_valid && !full) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rp_r <= '0;
    end else if (f.pop_ready && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule : eep_fifo

/* File: rtl/eep_slave.sv */
`timescale 1ns/1ps
// What this block does
// - Start is SDA falling while SCL high
// - Ignore the bus until a Start arrives
// - Stop is SDA rising while SCL high
// - Stop after unacknowledged read returns to standby
// - Receiver pulls SDA low in ninth clock
// - Sample SDA on each rising SCL edge
// - Select byte chip field must match straps
// - Select byte type field must match built-in type
// - Eighth select bit: one reads, zero writes
// - Acknowledge match, else release and stand by
// - Write select is followed by two address bytes
// - Address arrives high byte then low byte
// - Protect input during header blocks data writes
// - Only Stop in tenth slot starts programming
// - After programming, counter points past last byte
// - Busy programming: SDA released, bus ignored
// - Byte write acknowledged only when unprotected
// - In-page counter advances per accepted byte
// - Six check bits correct one error per word
// - Any byte write rewrites its whole word
// - Reads ignore protect; current and sequential forms
// - Read counter increments per byte and wraps
// - Missing master acknowledge ends the read
module eep_slave #(
  parameter int         ADDR_W     = eep_pkg::ADDR_W_DEF,
  parameter int         PAGE_W     = eep_pkg::PAGE_W_DEF,
  parameter int         FIFO_DEPTH = eep_pkg::FIFO_DEPTH_DEF,
  parameter bit         ECC_EN     = 1'b1,
  parameter logic [3:0] DEV_TYPE   = 4'h5, // Arbitrary value
  parameter int         WR_CYCLES  = eep_pkg::WR_CYCLES_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic [2:0] chip_select_straps_i,
  input  wire logic       write_protect_input_i,
  output logic            busy_o
);
  localparam int PAGE_BYTES = 1 << PAGE_W;
  localparam int PAGE_WORDS = PAGE_BYTES / eep_pkg::WORD_BYTES;
  localparam int MEM_WORDS  = (1 << ADDR_W) / eep_pkg::WORD_BYTES;
  localparam int WA_W       = ADDR_W - eep_pkg::WORD_SEL_W;
  localparam int CW_W       = PAGE_W - eep_pkg::WORD_SEL_W;
  localparam int ROW_W      = ADDR_W - PAGE_W;
  localparam int FW         = PAGE_W + eep_pkg::BYTE_W;
  localparam int TW         = $clog2(WR_CYCLES + 1);
  localparam int BW         = eep_pkg::BYTE_W;

  if (PAGE_W < 3 || ADDR_W <= PAGE_W || ADDR_W > 16 || ADDR_W <= BW ||
      WR_CYCLES < PAGE_WORDS + 1) begin : g_chk
    $error("eep_slave: parameters out of range");
  end

  // Pin synchronisers
  logic [eep_pkg::PIN_W-1:0] pins_s;
  logic                      scl_s;
  logic                      sda_s;
  logic                      wp_s;
  logic [2:0]                cs_s;

  eep_sync #(.W(eep_pkg::PIN_W)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({chip_select_straps_i, write_protect_input_i, sda_i, scl_i}),
    .q_o      (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign wp_s  = pins_s[2];
  assign cs_s  = pins_s[5:3];

  eep_fifo_if #(.W(FW)) wq ();

  eep_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .f        (wq.fifo)
  );

  eep_pkg::eep_state_t       state_r;
  logic                      scl_q_r;
  logic                      sda_q_r;
  logic [3:0]                bit_cnt_r;
  logic [BW-1:0]             rx_r;
  logic [BW-1:0]             tx_r;
  logic [BW-1:0]             rx_byte;
  logic                      ack_pend_r;
  logic                      rw_r;
  logic                      drive_low_r;
  logic                      slot10_r;
  logic                      wp_seen_r;
  logic [ADDR_W-1:0]         addr_r;
  logic [ROW_W-1:0]          row_r;
  logic [PAGE_W-1:0]         pg_off_r;
  logic [BW-1:0]             pg_data_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]     pg_vld_r;
  logic [eep_pkg::WORD_W-1:0] mem_r   [MEM_WORDS];
  logic [eep_pkg::CHK_W-1:0]  chk_r   [MEM_WORDS];
  logic [TW-1:0]             wtmr_r;
  logic [CW_W:0]             cw_r;

  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_ev;
  logic                      stop_ev;
  logic                      byte_done;
  logic                      ack_rise;
  logic                      sel_match;
  logic                      accept;
  logic                      busy;
  logic                      commit_en;
  logic                      wr_trig;
  logic [WA_W-1:0]           cw_addr;
  logic [eep_pkg::WORD_W-1:0] cur_word;
  logic [eep_pkg::WORD_W-1:0] merged;
  logic [ADDR_W-1:0]         last_addr;

  assign busy      = (state_r == eep_pkg::ST_BUSY);
  assign scl_rise  = scl_s && !scl_q_r;
  assign scl_fall  = !scl_s && scl_q_r;
  // SCL must be high on both consecutive samples, so glitches on SCL cannot fake these
  assign start_ev  = scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_ev   = scl_s && scl_q_r && !sda_q_r && sda_s;
  assign byte_done = scl_rise && (bit_cnt_r == eep_pkg::BIT_LAST);
  assign ack_rise  = scl_rise && (bit_cnt_r == eep_pkg::BIT_ACK);
  assign rx_byte   = {rx_r[BW-2:0], sda_s};

  assign sel_match =
    (rx_byte[eep_pkg::SEL_TYPE_MSB:eep_pkg::SEL_TYPE_LSB] == DEV_TYPE) &&
    (rx_byte[eep_pkg::SEL_CS_MSB:eep_pkg::SEL_CS_LSB] == cs_s);

  // A full FIFO refuses the byte and the master sees no acknowledge
  assign accept = !wp_seen_r && wq.push_ready;

  assign wq.push_valid = byte_done && (state_r == eep_pkg::ST_WDATA) && accept;
  assign wq.push_data  = {pg_off_r, rx_byte};
  // Draining stalls while the page is being committed
  assign wq.pop_ready  = !busy;

  assign wr_trig = stop_ev && slot10_r && (state_r == eep_pkg::ST_WDATA);

  function automatic logic [BW-1:0] byte_at(input logic [ADDR_W-1:0] a);
    logic [eep_pkg::WORD_W-1:0] w;
    w = mem_r[a[ADDR_W-1:eep_pkg::WORD_SEL_W]];
    if (ECC_EN) begin
      w = eep_pkg::ecc_fix(w, chk_r[a[ADDR_W-1:eep_pkg::WORD_SEL_W]]);
    end
    return w[a[eep_pkg::WORD_SEL_W-1:0]*BW +: BW];
  endfunction : byte_at

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q_r <= 1'b0;
      sda_q_r <= 1'b0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_r <= 4'h0;
      rx_r      <= 8'h00;
    end else if (start_ev) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise) begin
      rx_r      <= rx_byte;
      bit_cnt_r <= ack_rise ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= eep_pkg::ST_IDLE;
    end else if (busy) begin
      if (wtmr_r == '0) state_r <= eep_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_r <= eep_pkg::ST_SEL;
    end else if (stop_ev) begin
      state_r <= wr_trig ? eep_pkg::ST_BUSY : eep_pkg::ST_IDLE;
    end else if (byte_done && state_r == eep_pkg::ST_SEL && !sel_match) begin
      state_r <= eep_pkg::ST_IDLE;
    end else if (ack_rise) begin
      unique case (state_r)
        eep_pkg::ST_SEL:   state_r <= rw_r ? eep_pkg::ST_RDATA : eep_pkg::ST_AHI;
        eep_pkg::ST_AHI:   state_r <= eep_pkg::ST_ALO;
        eep_pkg::ST_ALO:   state_r <= eep_pkg::ST_WDATA;
        eep_pkg::ST_RDATA: begin
          if (sda_s) state_r <= eep_pkg::ST_IDLE;
        end
        eep_pkg::ST_IDLE, eep_pkg::ST_WDATA, eep_pkg::ST_BUSY: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_pend_r <= 1'b0;
      rw_r       <= 1'b0;
    end else if (start_ev || stop_ev || ack_rise) begin
      ack_pend_r <= 1'b0;
    end else if (byte_done) begin
      unique case (state_r)
        eep_pkg::ST_SEL: begin
          ack_pend_r <= sel_match;
          rw_r       <= rx_byte[eep_pkg::SEL_RW_BIT];
        end
        eep_pkg::ST_AHI, eep_pkg::ST_ALO: ack_pend_r <= 1'b1;
        eep_pkg::ST_WDATA: ack_pend_r <= accept;
        eep_pkg::ST_IDLE, eep_pkg::ST_RDATA, eep_pkg::ST_BUSY: ack_pend_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_r <= 8'h00;
    end else if (ack_rise && state_r == eep_pkg::ST_SEL && rw_r) begin
      tx_r <= byte_at(addr_r);
    end else if (ack_rise && state_r == eep_pkg::ST_RDATA) begin
      tx_r <= byte_at(addr_r + 1'b1);
    end else if (scl_fall && state_r == eep_pkg::ST_RDATA && bit_cnt_r < eep_pkg::BIT_ACK) begin
      tx_r <= {tx_r[BW-2:0], 1'b0};
    end
  end

  // Data changes only after SCL falls, so the master sees it stable at the rising edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_low_r <= 1'b0;
    end else if (start_ev || stop_ev || busy || state_r == eep_pkg::ST_IDLE) begin
      drive_low_r <= 1'b0;
    end else if (scl_fall) begin
      if (state_r == eep_pkg::ST_RDATA && bit_cnt_r < eep_pkg::BIT_ACK) begin
        drive_low_r <= !tx_r[BW-1];
      end else begin
        drive_low_r <= (bit_cnt_r == eep_pkg::BIT_ACK) && ack_pend_r;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot10_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      slot10_r <= 1'b0;
    end else if (scl_rise) begin
      // The Stop's own SCL rise lies in the tenth slot, so the flag must outlive that one rise
      slot10_r <= ack_rise ? (ack_pend_r && (state_r == eep_pkg::ST_WDATA)) :
                             (slot10_r && (bit_cnt_r == 4'h0));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_seen_r <= 1'b0;
    end else if (start_ev) begin
      wp_seen_r <= wp_s;
    end else if (wp_s && (state_r == eep_pkg::ST_SEL || state_r == eep_pkg::ST_AHI ||
                          state_r == eep_pkg::ST_ALO)) begin
      wp_seen_r <= 1'b1;
    end
  end

  assign last_addr = {row_r, PAGE_W'(pg_off_r - 1'b1)};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_r <= '0;
    end else if (busy) begin
      if (wtmr_r == '0) addr_r <= last_addr + 1'b1;
    end else if (byte_done && state_r == eep_pkg::ST_AHI) begin
      addr_r[ADDR_W-1:BW] <= rx_byte[ADDR_W-BW-1:0];
    end else if (byte_done && state_r == eep_pkg::ST_ALO) begin
      addr_r[BW-1:0] <= rx_byte;
    end else if (ack_rise && state_r == eep_pkg::ST_RDATA) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      row_r    <= '0;
      pg_off_r <= '0;
    end else if (ack_rise && state_r == eep_pkg::ST_ALO) begin
      row_r    <= addr_r[ADDR_W-1:PAGE_W];
      pg_off_r <= addr_r[PAGE_W-1:0];
    end else if (wq.push_valid && wq.push_ready) begin
      // Wraps to the start of the same row; the row bits never move
      pg_off_r <= pg_off_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wq.pop_valid && wq.pop_ready) begin
      pg_data_r[wq.pop_data[FW-1:BW]] <= wq.pop_data[BW-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pg_vld_r <= '0;
    end else if (start_ev && !busy) begin
      pg_vld_r <= '0;
    end else if (busy && wtmr_r == '0) begin
      pg_vld_r <= '0;
    end else if (wq.pop_valid && wq.pop_ready) begin
      pg_vld_r[wq.pop_data[FW-1:BW]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wtmr_r <= '0;
      cw_r   <= '0;
    end else if (wr_trig && !busy) begin
      wtmr_r <= TW'(WR_CYCLES - 1);
      cw_r   <= '0;
    end else if (busy) begin
      if (wtmr_r != '0) wtmr_r <= wtmr_r - 1'b1;
      if (commit_en) cw_r <= cw_r + 1'b1;
    end
  end

  assign commit_en = busy && (cw_r < (CW_W + 1)'(PAGE_WORDS));
  assign cw_addr   = {row_r, cw_r[CW_W-1:0]};
  assign cur_word  = ECC_EN ? eep_pkg::ecc_fix(mem_r[cw_addr], chk_r[cw_addr]) : mem_r[cw_addr];

  // Whole word is rewritten even for one byte, so check bits always match the data
  genvar b;
  generate
    for (b = 0; b < eep_pkg::WORD_BYTES; b++) begin : g_merge
      logic [PAGE_W-1:0] off;
      assign off = {cw_r[CW_W-1:0], eep_pkg::WORD_SEL_W'(b)};
      assign merged[b*BW +: BW] = pg_vld_r[off] ? pg_data_r[off] : cur_word[b*BW +: BW];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (commit_en) begin
      mem_r[cw_addr] <= merged;
      chk_r[cw_addr] <= eep_pkg::ecc_gen(merged);
    end
  end

  // Open-drain: the pin is only ever pulled low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !drive_low_r;
  assign busy_o     = busy;

endmodule : eep_slave

/* File: dv/eep_slave_sva.sv */
`timescale 1ns/1ps
module eep_slave_sva #(
  parameter int WR_CYCLES = 500
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_n_o,
  input  wire logic [2:0] chip_select_straps_i,
  input  wire logic       write_protect_input_i,
  input  wire logic       busy_o
);
  int busy_cnt_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_o ? busy_cnt_r + 1 : 0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("sda_o is not held low");
  AST_RST_QUIET: assert property (disable iff (1'b0) !arst_n_i |-> sda_oe_n_o && !busy_o)
    else $error("outputs active in reset");
  // Drive moves only inside a settled SCL low phase
  AST_DRV_SCL_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 3))
    else $error("sda drive changed outside scl low");
  AST_BUSY_STOP: assert property ($rose(busy_o) |-> scl_i && sda_i && $past(scl_i, 4))
    else $error("write cycle began without a stop");
  AST_BUSY_QUIET: assert property (busy_o |-> sda_oe_n_o)
    else $error("sda driven while busy");
  AST_BUSY_HOLD: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy dropped early");
  AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_cnt_r == WR_CYCLES)
    else $error("busy length wrong");
  AST_AFTER_BUSY: assert property ($fell(busy_o) |-> sda_oe_n_o [*3])
    else $error("sda driven as busy ended");
  COV_BUSY: cover property ($rose(busy_o));
  COV_DRIVE: cover property ($fell(sda_oe_n_o));
  COV_WP_ACK: cover property (write_protect_input_i && !sda_oe_n_o);
endmodule : eep_slave_sva

bind eep_slave eep_slave_sva #(.WR_CYCLES(WR_CYCLES)) i_eep_slave_sva (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .chip_select_straps_i(chip_select_straps_i),
  .write_protect_input_i(write_protect_input_i), .busy_o(busy_o));

/* File: dv/eep_i2c_master.sv */
`timescale 1ns/1ps
module eep_i2c_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  // SCL stands high between frames; it only moves inside these tasks
  task automatic bit_io(input logic v, output logic s);
    scl_o = 1'b0;
    tick(4);
    sda_o = v;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    s = sda_i;
    tick(4);
  endtask : bit_io
  task automatic start();
    scl_o = 1'b0;
    tick(4);
    sda_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_o = 1'b0;
    tick(8);
  endtask : start
  task automatic stop();
    scl_o = 1'b0;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_o = 1'b1;
    tick(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask : rbyte
endmodule : eep_i2c_master

/* File: dv/eep_slave_tb.sv */
`timescale 1ns/1ps
module eep_slave_tb;
  localparam int         WRC = 400;
  localparam logic [3:0] DT  = 4'h5;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wp       = 1'b0;
  logic [2:0]  cs       = 3'h0;
  logic [31:0] rs       = 32'h0000001F;
  logic [13:0] base;
  logic        scl;
  logic        msda;
  logic        sda_o;
  logic        oe_n;
  logic        busy;
  logic [7:0]  mem [logic [13:0]];
  int          error_cnt = 0;
  int          cmp_count = 0;
  wire         sda = oe_n ? msda : sda_o;

  eep_slave #(.WR_CYCLES(WRC)) i_eep_slave (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .chip_select_straps_i(cs), .write_protect_input_i(wp), .busy_o(busy));
  eep_i2c_master i_eep_i2c_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(msda));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Page offset wraps inside the row
  function automatic logic [13:0] nxt(input logic [13:0] a);
    return {a[13:6], a[5:0] + 6'h01};
  endfunction : nxt

  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic sel(input logic [3:0] t, input logic [2:0] c, input logic rw,
                     input logic [7:0] ek);
    logic k;
    i_eep_i2c_master.start();
    i_eep_i2c_master.wbyte({t, c, rw}, k);
    cmp_bit(k, ek[0]);
  endtask : sel
  task automatic addr(input logic [13:0] a);
    logic k;
    sel(DT, cs, 1'b0, 8'h00);
    i_eep_i2c_master.wbyte({2'h0, a[13:8]}, k);
    cmp_bit(k, 1'b0);
    i_eep_i2c_master.wbyte(a[7:0], k);
    cmp_bit(k, 1'b0);
  endtask : addr
  task automatic wr(input logic [13:0] a, input int n, input logic [7:0] dk);
    logic       k;
    logic [7:0] d;
    addr(a);
    for (int i = 0; i < n; i++) begin
      rs = xs(rs);
      d = rs[7:0];
      i_eep_i2c_master.wbyte(d, k);
      cmp_bit(k, dk[0]);
      if (dk == 8'h00) mem[a] = d;
      a = nxt(a);
    end
    i_eep_i2c_master.stop();
    for (int i = 0; i < 40 && busy !== 1'b1; i++) @(negedge clk_i);
    cmp_bit(busy, n > 0 && dk == 8'h00);
    if (busy === 1'b1) begin
      sel(DT, cs, 1'b0, 8'h01);
      i_eep_i2c_master.stop();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_i);
      cmp_bit(busy, 1'b0);
    end
  endtask : wr
  task automatic rd(input logic rnd, input logic [13:0] a, input int n);
    logic [7:0] d;
    if (rnd) addr(a);
    sel(DT, cs, 1'b1, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_eep_i2c_master.rbyte(i == n - 1, d);
      cmp_byte(d, mem[a]);
      a = a + 14'h0001;
    end
    cmp_bit(oe_n, 1'b1);
    i_eep_i2c_master.stop();
  endtask : rd

  initial begin
    #400000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rs = xs(rs);
    cs = rs[2:0];
    base = {rs[13:6], 3'h0, rs[18:16]};
    sel(DT ^ 4'h1, cs, 1'b0, 8'h01);
    i_eep_i2c_master.stop();
    sel(DT, cs ^ 3'h4, 1'b1, 8'h01);
    i_eep_i2c_master.stop();
    wr(base, 8, 8'h00);
    wr(base, 4, 8'h00);
    rd(1'b0, base + 14'h0004, 4);
    rd(1'b1, base, 8);
    wr({base[13:6], 6'h3E}, 4, 8'h00);
    rd(1'b1, {base[13:6], 6'h00}, 2);
    rd(1'b1, {base[13:6], 6'h3E}, 2);
    wr(base + 14'h0001, 1, 8'h00);
    rd(1'b1, base, 4);
    wp = 1'b1;
    wr(base, 2, 8'h01);
    rd(1'b1, base, 2);
    wp = 1'b0;
    wr(base, 0, 8'h00);
    wr(14'h3FFF, 1, 8'h00);
    wr(14'h0000, 1, 8'h00);
    rd(1'b1, 14'h3FFF, 2);
    conclude();
  end
endmodule : eep_slave_tb
